// ==== src/cptmx_top.sv ====
// Codec port terminal mode mux with adaptive master clock and registers.
// Assumes a one-cycle register port on mclk_i and pin inputs from outside.
// Contract
// - Mode 0 to 5 comes from the mode field of config register one.
// - Each of six terminals takes a fixed function and direction per mode.
// - Frame sync is two-way in mode 0, an output in modes 1 to 5.
// - Serial clock two-way in 0, output in 1,4,5, input in 2,3.
// - Data out is a serial data output in every mode.
// - Data in is input; first data in mode 4, second in mode 5.
// - Reset pin is codec reset in modes 0-4, second serial clock in 5.
// - Aux unused in 0,2; control out 1; data in 3,4; second LR clock 5.
// - Terminals without a function are still driven as outputs.
// - General mode sets frame sync and serial clock direction separately.
// - Master and serial clocks never come from the fixed clock generator.
// - Adaptive generator makes the master clock for port and codec.
// - Generator counts master clocks between frame starts; software reads it.
// - Software corrections steer the generator to the wanted count per frame.
// - External master clock may be chosen as the port clock source.
// - With external master clock, own serial clock and sync derive from it.
// - Reset returns all port logic, mode field included, to defaults.
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "cptmx_map.svh"
module cptmx_top
  import cptmx_pkg::*;
(
  input wire logic mclk_i,              // System clock, 100 MHz
  input wire logic reset_i,             // Synchronous reset, high
  input wire logic [3:0] addr_i,        // Register address
  input wire logic [7:0] wdata_i,       // Register write data
  input wire logic wr_i,                // Write strobe
  input wire logic rd_i,                // Read strobe
  output logic [7:0] rdata_o,           // Read data, cycle after rd_i
  input wire logic sof_i,               // Start of frame pulse
  input wire logic tx_data_i,           // Serial data to send
  input wire logic frame_ctrl_i,        // Frame control level, mode 1
  input wire logic master_clock_in_i,   // External master clock pin
  output logic master_clock_out_o,      // Generated master clock pin
  input wire logic frame_sync_i,        // Frame sync pin in
  output logic frame_sync_o,            // Frame sync pin out
  output logic frame_sync_oe_n_o,       // Frame sync drive, low drives
  input wire logic serial_clock_i,      // Serial clock pin in
  output logic serial_clock_o,          // Serial clock pin out
  output logic serial_clock_oe_n_o,     // Serial clock drive, low drives
  output logic data_out_o,              // Serial data out pin
  input wire logic data_in_i,           // Serial data in pin
  output logic reset_out_o,             // Codec reset or second clock pin
  input wire logic aux_i,               // Aux terminal in
  output logic aux_o,                   // Aux terminal out
  output logic aux_oe_n_o,              // Aux drive, low drives
  output logic rx_data1_o,              // First received data line
  output logic rx_data2_o,              // Second received data line
  output logic sclk_rise_o,             // Pulse on serial clock rise
  output logic sclk_fall_o,             // Pulse on serial clock fall
  output logic frame_level_o            // Frame sync level in use
);
  cptmx_mode_t mode_q, next_mode;
  logic [7:0] cfg_q, next_cfg, sdiv_q, next_sdiv, fsdiv_q, next_fsdiv;
  logic [7:0] cnt_hi_hold, next_cnt_hi_hold, next_rdata;
  logic [7:0] sdiv_cnt, next_sdiv_cnt, fs_cnt, next_fs_cnt;
  logic [23:0] inc_q, next_inc;
  logic [15:0] acg_count;
  logic [4:0] pins_sync;
  logic acg_clk, acg_rise, mclk_edge, sclk_ext, sclk_fall_ev, sclk_rise_ev;
  logic mclkin_prev, sclkin_prev, next_mclkin_prev, next_sclkin_prev;
  logic sclk_int, next_sclk_int, fs_int, next_fs_int;
  logic next_fs_pin, next_fs_oe_n, next_sclk_pin, next_sclk_oe_n;
  logic next_rst_pin, next_aux_pin, next_aux_oe_n;
  logic next_rx1, next_rx2, next_frame_level;

  // Register file
  always_comb begin
    next_mode = mode_q;
    next_cfg = cfg_q;
    next_sdiv = sdiv_q;
    next_fsdiv = fsdiv_q;
    next_inc = inc_q;
    next_cnt_hi_hold = cnt_hi_hold;
    next_rdata = 8'h00;
    if (wr_i) begin
      unique case (addr_i)
        `CPTMX_OFF_CFG1: begin
          next_cfg = wdata_i;
          next_mode = cptmx_mode_t'(wdata_i[`CPTMX_F_MODE]);
        end
        `CPTMX_OFF_SDIV: next_sdiv = wdata_i;
        `CPTMX_OFF_FSDIV: next_fsdiv = wdata_i;
        `CPTMX_OFF_FREQ0: next_inc[`CPTMX_BYTE0] = wdata_i;
        `CPTMX_OFF_FREQ1: next_inc[`CPTMX_BYTE1] = wdata_i;
        `CPTMX_OFF_FREQ2: next_inc[`CPTMX_BYTE2] = wdata_i;
        default: ;
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        `CPTMX_OFF_CFG1: next_rdata = {cfg_q[7:3], mode_q};
        `CPTMX_OFF_SDIV: next_rdata = sdiv_q;
        `CPTMX_OFF_FSDIV: next_rdata = fsdiv_q;
        `CPTMX_OFF_FREQ0: next_rdata = inc_q[`CPTMX_BYTE0];
        `CPTMX_OFF_FREQ1: next_rdata = inc_q[`CPTMX_BYTE1];
        `CPTMX_OFF_FREQ2: next_rdata = inc_q[`CPTMX_BYTE2];
        `CPTMX_OFF_CNT0: begin
          // Low byte read freezes the high byte against a tear
          next_rdata = acg_count[`CPTMX_BYTE0];
          next_cnt_hi_hold = acg_count[`CPTMX_BYTE1];
        end
        `CPTMX_OFF_CNT1: next_rdata = cnt_hi_hold;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mode_q <= CPTMX_GP;
      cfg_q <= `CPTMX_RST_CFG1;
      sdiv_q <= `CPTMX_RST_SDIV;
      fsdiv_q <= `CPTMX_RST_FSDIV;
      inc_q <= `CPTMX_RST_FREQ;
      cnt_hi_hold <= 8'h00;
      rdata_o <= 8'h00;
    end else begin
      mode_q <= next_mode;
      cfg_q <= next_cfg;
      sdiv_q <= next_sdiv;
      fsdiv_q <= next_fsdiv;
      inc_q <= next_inc;
      cnt_hi_hold <= next_cnt_hi_hold;
      rdata_o <= next_rdata;
    end
  end

  cptmx_acg u_acg (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .inc_i(inc_q),
    .sof_i(sof_i),
    .mclk_out_o(acg_clk),
    .mclk_rise_o(acg_rise),
    .count_o(acg_count)
  );

  // Bit order: aux, data in, serial clock, frame sync, master clock in
  cptmx_sync #(.W(5)) u_pin_sync (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .async_i({aux_i, data_in_i, serial_clock_i, frame_sync_i,
              master_clock_in_i}),
    .sync_o(pins_sync)
  );

  // Serial clock is taken from the pin in link-clocked modes
  assign sclk_ext = (mode_q == CPTMX_AC97V1) || (mode_q == CPTMX_AC97V2) ||
                    ((mode_q == CPTMX_GP) && !cfg_q[`CPTMX_F_SCLK_OUT]);
  assign sclk_rise_ev = sclk_ext ? (pins_sync[2] & ~sclkin_prev)
                                 : (next_sclk_int & ~sclk_int);
  assign sclk_fall_ev = sclk_ext ? (~pins_sync[2] & sclkin_prev)
                                 : (~next_sclk_int & sclk_int);
  // Only the adaptive clock or the pin may clock the port
  assign mclk_edge = cfg_q[`CPTMX_F_MCLK_IN] ?
                     (pins_sync[0] & ~mclkin_prev) : acg_rise;

  // Port clock dividers
  always_comb begin
    next_mclkin_prev = pins_sync[0];
    next_sclkin_prev = pins_sync[2];
    next_sdiv_cnt = sdiv_cnt;
    next_sclk_int = sclk_int;
    next_fs_cnt = fs_cnt;
    next_fs_int = fs_int;
    if (mclk_edge) begin
      if (sdiv_cnt >= sdiv_q) begin
        next_sdiv_cnt = 8'h00;
        next_sclk_int = ~sclk_int;
      end else begin
        next_sdiv_cnt = sdiv_cnt + 8'h01;
      end
    end
    if (sclk_fall_ev) begin
      if (fs_cnt >= fsdiv_q) begin
        next_fs_cnt = 8'h00;
        next_fs_int = ~fs_int;
      end else begin
        next_fs_cnt = fs_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mclkin_prev <= 1'b0;
      sclkin_prev <= 1'b0;
      sdiv_cnt <= 8'h00;
      sclk_int <= 1'b0;
      fs_cnt <= 8'h00;
      fs_int <= 1'b0;
    end else begin
      mclkin_prev <= next_mclkin_prev;
      sclkin_prev <= next_sclkin_prev;
      sdiv_cnt <= next_sdiv_cnt;
      sclk_int <= next_sclk_int;
      fs_cnt <= next_fs_cnt;
      fs_int <= next_fs_int;
    end
  end

  // Terminal function and direction per mode
  always_comb begin
    next_fs_pin = fs_int;
    next_fs_oe_n = 1'b0;
    next_sclk_pin = sclk_int;
    next_sclk_oe_n = 1'b0;
    next_rst_pin = ~cfg_q[`CPTMX_F_CRST];
    next_aux_pin = 1'b0;
    next_aux_oe_n = 1'b0;
    next_rx1 = pins_sync[3];
    next_rx2 = 1'b0;
    unique case (mode_q)
      CPTMX_GP: begin
        next_fs_oe_n = ~cfg_q[`CPTMX_F_FS_OUT];
        next_sclk_oe_n = ~cfg_q[`CPTMX_F_SCLK_OUT];
      end
      CPTMX_FSER: next_aux_pin = frame_ctrl_i;
      CPTMX_AC97V1: next_sclk_oe_n = 1'b1;
      CPTMX_AC97V2: begin
        next_sclk_oe_n = 1'b1;
        next_aux_oe_n = 1'b1;
        next_rx2 = pins_sync[4];
      end
      CPTMX_I2S_ONE: begin
        next_aux_oe_n = 1'b1;
        next_rx2 = pins_sync[4];
      end
      CPTMX_I2S_TWO: begin
        next_rst_pin = sclk_int;
        next_aux_pin = fs_int;
        next_rx1 = 1'b0;
        next_rx2 = pins_sync[3];
      end
      // Codes 6 and 7 fall back to general mode with both driven
      default: ;
    endcase
    next_frame_level = (next_fs_oe_n) ? pins_sync[1] : fs_int;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      frame_sync_o <= 1'b0;
      frame_sync_oe_n_o <= 1'b1;
      serial_clock_o <= 1'b0;
      serial_clock_oe_n_o <= 1'b1;
      data_out_o <= 1'b0;
      reset_out_o <= 1'b0;
      aux_o <= 1'b0;
      aux_oe_n_o <= 1'b0;
      rx_data1_o <= 1'b0;
      rx_data2_o <= 1'b0;
      sclk_rise_o <= 1'b0;
      sclk_fall_o <= 1'b0;
      frame_level_o <= 1'b0;
      master_clock_out_o <= 1'b0;
    end else begin
      frame_sync_o <= next_fs_pin;
      frame_sync_oe_n_o <= next_fs_oe_n;
      serial_clock_o <= next_sclk_pin;
      serial_clock_oe_n_o <= next_sclk_oe_n;
      data_out_o <= tx_data_i;
      reset_out_o <= next_rst_pin;
      aux_o <= next_aux_pin;
      aux_oe_n_o <= next_aux_oe_n;
      rx_data1_o <= next_rx1;
      rx_data2_o <= next_rx2;
      sclk_rise_o <= sclk_rise_ev;
      sclk_fall_o <= sclk_fall_ev;
      frame_level_o <= next_frame_level;
      master_clock_out_o <= acg_clk;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  sequence s_cfg_write;
    wr_i && addr_i == `CPTMX_OFF_CFG1 && wdata_i[`CPTMX_F_MODE] <= 3'h5;
  endsequence
  property p_mode_write;
    s_cfg_write |=> mode_q == $past(wdata_i[`CPTMX_F_MODE]) ##1 
      frame_sync_oe_n_o == ($past(mode_q, 1) == CPTMX_GP &&
                            !cfg_q[`CPTMX_F_FS_OUT]);
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mode write not reflected on frame sync direction");
  property p_fs_out;
    mode_q != CPTMX_GP && mode_q <= CPTMX_I2S_TWO |=> !frame_sync_oe_n_o;
  endproperty
  a_fs_out: assert property (p_fs_out)
    else $error("frame sync not driven in a serial mode");
  property p_sclk_in;
    mode_q == CPTMX_AC97V1 || mode_q == CPTMX_AC97V2 |=> serial_clock_oe_n_o;
  endproperty
  a_sclk_in: assert property (p_sclk_in)
    else $error("serial clock driven while codec supplies it");
  property p_dout;
    1'b1 |=> data_out_o == $past(tx_data_i);
  endproperty
  a_dout: assert property (p_dout)
    else $error("data out does not follow transmit data");
  property p_second_clk;
    mode_q == CPTMX_I2S_TWO |=> reset_out_o == serial_clock_o &&
                                aux_o == frame_sync_o;
  endproperty
  a_second_clk: assert property (p_second_clk)
    else $error("second clock pair does not match the first");
  property p_nc_driven;
    mode_q == CPTMX_GP || mode_q == CPTMX_AC97V1 |=> !aux_oe_n_o && !aux_o;
  endproperty
  a_nc_driven: assert property (p_nc_driven)
    else $error("unused aux terminal left undriven");
  property p_gp_dir;
    mode_q == CPTMX_GP && !cfg_q[`CPTMX_F_FS_OUT] && $stable(cfg_q)
      |=> frame_sync_oe_n_o && frame_level_o == $past(pins_sync[1]);
  endproperty
  a_gp_dir: assert property (p_gp_dir)
    else $error("general mode frame sync direction ignored");
  property p_rx_second;
    mode_q == CPTMX_I2S_TWO |=> rx_data2_o == $past(pins_sync[3]) &&
                                !rx_data1_o;
  endproperty
  a_rx_second: assert property (p_rx_second)
    else $error("data in not routed to second input");
  property p_reset_mode;
    disable iff (1'b0) reset_i |=> mode_q == CPTMX_GP && frame_sync_oe_n_o;
  endproperty
  a_reset_mode: assert property (p_reset_mode)
    else $error("reset did not restore general mode");
endmodule

// ==== src/cptmx_map.svh ====
// Register offsets, field positions and reset values of the codec port mux.
// Included by the mux top; holds definitions only.
`ifndef CPTMX_MAP_SVH
`define CPTMX_MAP_SVH

`define CPTMX_OFF_CFG1 4'h0
`define CPTMX_OFF_SDIV 4'h1
`define CPTMX_OFF_FSDIV 4'h2
`define CPTMX_OFF_FREQ0 4'h3
`define CPTMX_OFF_FREQ1 4'h4
`define CPTMX_OFF_FREQ2 4'h5
`define CPTMX_OFF_CNT0 4'h6
`define CPTMX_OFF_CNT1 4'h7

`define CPTMX_F_MODE 2:0
`define CPTMX_F_FS_OUT 3
`define CPTMX_F_SCLK_OUT 4
`define CPTMX_F_MCLK_IN 5
`define CPTMX_F_CRST 6

`define CPTMX_RST_CFG1 8'h40
`define CPTMX_RST_SDIV 8'h03
`define CPTMX_RST_FSDIV 8'h1f
`define CPTMX_RST_FREQ 24'h3d70a4
`define CPTMX_BYTE0 7:0
`define CPTMX_BYTE1 15:8
`define CPTMX_BYTE2 23:16

`endif

// ==== src/cptmx_pkg.sv ====
// Types shared by the codec port terminal mux files.
// Assumes the register map header supplies all numbers.
package cptmx_pkg;
  typedef enum logic [2:0] {
    CPTMX_GP = 3'h0,
    CPTMX_FSER = 3'h1,
    CPTMX_AC97V1 = 3'h2,
    CPTMX_AC97V2 = 3'h3,
    CPTMX_I2S_ONE = 3'h4,
    CPTMX_I2S_TWO = 3'h5
  } cptmx_mode_t;
endpackage

// ==== src/cptmx_sync.sv ====
// Two-flop synchroniser for a group of levels from outside mclk_i.
// Assumes each bit is a slow level; bits are not coherent as a word.
`timescale 1ns/10ps
module cptmx_sync #(
  parameter int W = 1
) (
  input wire logic mclk_i,           // System clock
  input wire logic reset_i,          // Synchronous reset, high
  input wire logic [W-1:0] async_i,  // Levels from pins
  output logic [W-1:0] sync_o        // Synchronised levels
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_sync;

  always_comb begin
    next_stage1 = async_i;
    next_sync = stage1;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= next_stage1;
      sync_o <= next_sync;
    end
  end
endmodule

// ==== src/cptmx_acg.sv ====
// Adaptive master clock generator: phase accumulator plus per-frame count.
// Assumes sof_i is a one-cycle pulse from the frame timer on mclk_i.
`timescale 1ns/10ps
module cptmx_acg (
  input wire logic mclk_i,            // System clock
  input wire logic reset_i,           // Synchronous reset, high
  input wire logic [23:0] inc_i,      // Phase step from soft loop
  input wire logic sof_i,             // Start of frame pulse
  output logic mclk_out_o,            // Generated master clock
  output logic mclk_rise_o,           // Pulse on each generated rise
  output logic [15:0] count_o         // Rises in the last frame
);
  logic [23:0] acc;
  logic [23:0] next_acc;
  logic [15:0] run_cnt;
  logic [15:0] next_run_cnt;
  logic [15:0] next_count;
  logic next_rise;

  // Step size sets the frequency; corrections take effect next cycle
  always_comb begin
    next_acc = acc + inc_i;
    next_rise = ~acc[23] & next_acc[23];
    next_count = count_o;
    next_run_cnt = run_cnt + {15'h0000, mclk_rise_o};
    if (sof_i) begin
      next_count = run_cnt + {15'h0000, mclk_rise_o};
      next_run_cnt = 16'h0000;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      acc <= 24'h000000;
      mclk_out_o <= 1'b0;
      mclk_rise_o <= 1'b0;
      run_cnt <= 16'h0000;
      count_o <= 16'h0000;
    end else begin
      acc <= next_acc;
      mclk_out_o <= next_acc[23];
      mclk_rise_o <= next_rise;
      run_cnt <= next_run_cnt;
      count_o <= next_count;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  property p_count_latch;
    sof_i |=> count_o == $past(run_cnt) + {15'h0000, $past(mclk_rise_o)};
  endproperty
  a_count_latch: assert property (p_count_latch)
    else $error("frame count not latched at start of frame");

  property p_count_bound;
    sof_i ##1 !sof_i [*3] ##1 sof_i |=> count_o <= 16'h0004;
  endproperty
  a_count_bound: assert property (p_count_bound)
    else $error("frame count exceeds cycles in frame");
endmodule

// ==== sim/cptmx_codec.sv ====
// Behavioural codec on the far side of the six port terminals.
// Assumes the bench picks the data levels and whether the bit clock runs.
`timescale 1ns/10ps
module cptmx_codec (
  input wire logic run_i,       // Bit clock runs
  input wire logic d1_i,        // Level to send on data in
  input wire logic d2_i,        // Level to send on aux
  input wire logic fs_o_i,      // Mux frame sync out
  input wire logic fs_oe_n_i,   // Mux frame sync drive, low drives
  input wire logic sc_o_i,      // Mux serial clock out
  input wire logic sc_oe_n_i,   // Mux serial clock drive, low drives
  input wire logic aux_o_i,     // Mux aux out
  input wire logic aux_oe_n_i,  // Mux aux drive, low drives
  output logic fs_pin_o,        // Frame sync wire
  output logic sc_pin_o,        // Serial clock wire
  output logic aux_pin_o,       // Aux wire
  output logic din_o,           // Data in wire
  output logic mck_o            // Shared master clock
);
  logic bclk = 1'b0;
  logic fs_c = 1'b0;
  logic aux_c = 1'b0;
  int n = 0;
  initial begin
    din_o = 1'b0;
    mck_o = 1'b0;
    forever #40 mck_o = ~mck_o; // Crystal runs free, both ends share it
  end
  // Bit clock stands still while idle
  always #80 bclk = run_i ? ~bclk : 1'b0;
  // Data launched on the wire's falling clock edge
  always @(negedge sc_pin_o) begin
    din_o <= d1_i;
    aux_c <= d2_i;
    n <= n + 1;
    if (n % 16 == 15) begin
      fs_c <= ~fs_c;
    end
  end
  assign fs_pin_o = fs_oe_n_i ? fs_c : fs_o_i;
  assign sc_pin_o = sc_oe_n_i ? bclk : sc_o_i;
  assign aux_pin_o = aux_oe_n_i ? aux_c : aux_o_i;
endmodule

// ==== sim/cptmx_bench.sv ====
// Self-checking bench for the codec port terminal mux.
// Assumes the codec model in cptmx_codec.sv and the register map header.
`timescale 1ns/10ps
`include "cptmx_map.svh"
module codec_port_terminal_mode_mux_bench;
  logic mclk_i, reset_i, wr_i, rd_i, sof_i, tx_data_i, frame_ctrl_i;
  logic [3:0] addr_i;
  logic [7:0] wdata_i, rdata_o, v, lo;
  logic mci, fs_pin, fs_o, fs_oe_n, sc_pin, sc_o, sc_oe_n, din;
  logic aux_pin, aux_o, aux_oe_n, data_out_o, reset_out_o;
  logic rx1, rx2, sclk_rise_o, run, d1, d2, r;
  logic [31:0] seed = 32'h00000887;
  logic [23:0] step;
  logic [31:0] x;
  logic mco, mco_q, sclk_fall_o, flv;
  int mc_cnt = 0;
  int sf_cnt = 0;
  longint e;
  int failures = 0;
  int checks = 0;
  int sr_cnt = 0;
  int cyc = 0;
  localparam logic [7:0] RST_TAB [9] = '{8'h40, 8'h03, 8'h1f, 8'ha4,
    8'h70, 8'h3d, 8'h00, 8'h00, 8'h00};

  cptmx_top dut_u (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sof_i(sof_i), .tx_data_i(tx_data_i), .frame_ctrl_i(frame_ctrl_i),
    .master_clock_in_i(mci), .master_clock_out_o(mco), .frame_sync_i(fs_pin),
    .frame_sync_o(fs_o), .frame_sync_oe_n_o(fs_oe_n),
    .serial_clock_i(sc_pin), .serial_clock_o(sc_o),
    .serial_clock_oe_n_o(sc_oe_n), .data_out_o(data_out_o),
    .data_in_i(din), .reset_out_o(reset_out_o), .aux_i(aux_pin),
    .aux_o(aux_o), .aux_oe_n_o(aux_oe_n), .rx_data1_o(rx1),
    .rx_data2_o(rx2), .sclk_rise_o(sclk_rise_o),
    .sclk_fall_o(sclk_fall_o), .frame_level_o(flv));
  cptmx_codec codec_u (.run_i(run), .d1_i(d1), .d2_i(d2), .fs_o_i(fs_o),
    .fs_oe_n_i(fs_oe_n), .sc_o_i(sc_o), .sc_oe_n_i(sc_oe_n),
    .aux_o_i(aux_o), .aux_oe_n_i(aux_oe_n), .fs_pin_o(fs_pin),
    .sc_pin_o(sc_pin), .aux_pin_o(aux_pin), .din_o(din), .mck_o(mci));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cyc++;
    if (sclk_rise_o === 1'b1) begin
      sr_cnt++;
    end
    if (sclk_fall_o === 1'b1) begin
      sf_cnt++;
    end
    if (mco === 1'b1 && mco_q === 1'b0) begin
      mc_cnt++;
    end
    mco_q = mco;
    if (cyc == 60000) begin
      failures++;
      stop_test();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Drive-off bits {frame sync, serial clock, aux}; 6 and 7 act as 0
  function automatic logic [15:0] exp_oe(input logic [2:0] m,
                                          input logic [1:0] dir);
    case (m)
      3'h1, 3'h5: return 16'h0000;
      3'h2: return 16'h0002;
      3'h3: return 16'h0003;
      3'h4: return 16'h0001;
      default: return {13'h0, ~dir[0], ~dir[1], 1'b0};
    endcase
  endfunction

  function automatic logic [15:0] trio();
    return {13'h0, fs_oe_n, sc_oe_n, aux_oe_n};
  endfunction

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    checks++;
    if (g !== x) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic chk_rng(input logic [15:0] g, input int l, input int h);
    checks++;
    if ($isunknown(g) || g < l || g > h) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, g, l, h);
    end
  endtask

  task automatic set_step(input logic [23:0] s);
    wr(`CPTMX_OFF_FREQ0, s[7:0]);
    wr(`CPTMX_OFF_FREQ1, s[15:8]);
    wr(`CPTMX_OFF_FREQ2, s[23:16]);
  endtask

  task automatic stop_test();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    {reset_i, wr_i, rd_i, sof_i, tx_data_i, frame_ctrl_i} = 6'b100000;
    {addr_i, wdata_i, run, d1, d2} = '0;
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    run <= 1'b1;
    #1 chk(trio(), 16'h0006);
    chk({15'h0, reset_out_o}, 16'h0000);
    for (int a = 0; a < 9; a++) begin
      rd(a[3:0], v);
      chk({8'h0, v}, {8'h0, RST_TAB[a]});
    end
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(`CPTMX_OFF_CFG1, {3'b000, i[1:0], 3'h0});
      settle(4);
      chk(trio(), exp_oe(3'h0, i[1:0]));
    end
    $display("test direction done");
    for (int m = 0; m < 16; m++) begin
      wr(`CPTMX_OFF_CFG1, {1'b0, m[3], 3'b011, m[2:0]});
      rd(`CPTMX_OFF_CFG1, v);
      chk({8'h0, v}, {9'h0, m[3], 3'b011, m[2:0]});
      x = rnd();
      d1 <= x[3];
      d2 <= x[7];
      frame_ctrl_i <= x[5];
      settle(100);
      chk(trio(), exp_oe(m[2:0], 2'b11));
      chk({15'h0, flv}, {15'h0, fs_o});
      if (m[2:0] != 3'h5) begin
        chk({15'h0, reset_out_o}, {15'h0, ~m[3]});
      end
      if (m[2:0] == 3'h1) begin
        chk({15'h0, aux_o}, {15'h0, frame_ctrl_i});
      end
      case (m[2:0])
        3'h1, 3'h2: chk({15'h0, rx1}, {15'h0, d1});
        3'h3: chk({15'h0, rx2}, {15'h0, d2});
        3'h4: chk({14'h0, rx1, rx2}, {14'h0, d1, d2});
        3'h5: chk({14'h0, rx1, rx2}, {14'h0, 1'b0, d1});
        default: ;
      endcase
      sr_cnt = 0;
      repeat (8) begin
        x = rnd();
        r = x[9];
        @(posedge mclk_i);
        tx_data_i <= r;
        settle(1);
        chk({15'h0, data_out_o}, {15'h0, r});
        if (m[2:0] == 3'h5) begin
          chk({14'h0, reset_out_o, aux_o}, {14'h0, sc_o, fs_o});
        end
      end
      if (m[2:0] == 3'h5) begin
        settle(100);
        chk_rng(sr_cnt[15:0], 1, 1000);
      end
    end
    $display("test modes done");
    repeat (8) begin
      addr_i <= 4'h0;
      v = 8'(1 + rnd() % 5);
      x = rnd();
      lo = x[7:0];
      wr(v[3:0], lo);
      rd(v[3:0], v);
      chk({8'h0, v}, {8'h0, lo});
    end
    wr(4'hc, 8'h5a);
    rd(4'hc, v);
    chk({8'h0, v}, 16'h0000);
    $display("test registers done");
    repeat (3) begin
      x = rnd();
      step = 24'h100000 + {2'b00, x[21:0]};
      set_step(step);
      repeat (3) begin
        repeat (1999) @(posedge mclk_i);
        sof_i <= 1'b1;
        @(posedge mclk_i);
        sof_i <= 1'b0;
      end
      rd(`CPTMX_OFF_CNT0, lo);
      rd(`CPTMX_OFF_CNT1, v);
      e = (longint'(step) * 2000) >> 24;
      chk_rng({v, lo}, int'(e) - 2, int'(e) + 2);
    end
    // Short frame of four cycles: step caps the rises at two
    sof_i <= 1'b1;
    @(posedge mclk_i);
    sof_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    sof_i <= 1'b1;
    @(posedge mclk_i);
    sof_i <= 1'b0;
    rd(`CPTMX_OFF_CNT0, lo);
    rd(`CPTMX_OFF_CNT1, v);
    chk_rng({v, lo}, 0, 2);
    $display("test adaptive clock done");
    set_step(24'h07ae14);
    wr(`CPTMX_OFF_SDIV, 8'h00);
    for (int s = 0; s < 2; s++) begin
      wr(`CPTMX_OFF_CFG1, {2'b01, s[0], 5'h01});
      settle(50);
      sr_cnt = 0;
      sf_cnt = 0;
      mc_cnt = 0;
      settle(1600);
      if (s == 1) begin
        chk_rng(sr_cnt[15:0], 95, 205);
        chk_rng(sf_cnt[15:0], 95, 205);
      end else begin
        chk_rng(sr_cnt[15:0], 20, 52);
        chk_rng(sf_cnt[15:0], 20, 52);
      end
      chk_rng(mc_cnt[15:0], 46, 50);
    end
    $display("test clock source done");
    wr(`CPTMX_OFF_CFG1, 8'h05);
    @(posedge mclk_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    #1 chk(trio(), 16'h0006);
    chk({15'h0, reset_out_o}, 16'h0000);
    rd(`CPTMX_OFF_CFG1, v);
    chk({8'h0, v}, 16'h0040);
    $display("test second reset done");
    stop_test();
  end
endmodule
